// ==== verilog/spc_port.sv ====
// six pin port with direction, pull-ups, analog select and change detect
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"
module spc_port (
  // clock and resets
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic porReset,
  input wire logic masterClearPinEnable,
  // register port
  input wire spc_pkg::spc_addr_t regAddr,
  input wire spc_pkg::spc_byte_t regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output spc_pkg::spc_byte_t regRdData,
  // pins
  input wire spc_pkg::spc_pins_t pinIn,
  output spc_pkg::spc_pins_t pinOut,
  output spc_pkg::spc_pins_t pinOe,
  output spc_pkg::spc_pins_t pinPullup,
  // core signals
  output logic changeIrq,
  output logic changeWake
);
  import spc_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  spc_pins_t outLatch;
  spc_pins_t portDirection;
  spc_pins_t pinPullupEnable;
  spc_pins_t pinChangeEnable;
  spc_pins_t pinAnalogSelect;
  spc_pins_t lastRead;
  logic changeInterruptFlag;
  logic changeInterruptEnable;
  logic globalPullupDisable;
  spc_pins_t digitalIn;
  spc_pins_t mismatch;
  spc_pins_t next_outLatch;
  spc_byte_t next_rdData;
  logic anyMismatch;
  logic portAccess;

  function automatic logic hitReg(input spc_addr_t a, input spc_addr_t r);
    hitReg = (a == r);
  endfunction

  // pin drive and pull-up per pin
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : gPin
      assign pinOe[g] = ~portDirection[g]; // R01 R04 R18
      assign pinOut[g] = outLatch[g]; // R01
      // pull-up ignores analog select on purpose
      assign pinPullup[g] = ((g == `SPC_PIN3) && masterClearPinEnable) | // R09
        (pinPullupEnable[g] & portDirection[g] & ~globalPullupDisable); // R06 R07 R08 R19
      assign digitalIn[g] = pinIn[g] & ~pinAnalogSelect[g]; // R05 R17
    end
  endgenerate

  // mismatch against last-read value
  assign mismatch = (digitalIn ^ lastRead) & pinChangeEnable; // R12
  assign anyMismatch = |mismatch; // R12
  assign portAccess = (regRead | regWrite) & hitReg(regAddr, `SPC_ADDR_PORT);
  // write merges new bits onto sampled pins; all six bits written, so the sample is fully replaced
  assign next_outLatch = (regWrData[5:0] & `SPC_PIN_MASK) | (digitalIn & ~`SPC_PIN_MASK); // R02 R03
  assign changeIrq = changeInterruptFlag & changeInterruptEnable; // R11
  assign changeWake = changeInterruptFlag & changeInterruptEnable; // R13

  // read mux, reserved bits zero
  always_comb begin
    next_rdData = 8'h00;
    case (regAddr)
      `SPC_ADDR_PORT: next_rdData = {2'h0, digitalIn}; // R02 R05
      `SPC_ADDR_DIR: next_rdData = {2'h0, portDirection}; // R20
      `SPC_ADDR_PULLUP: next_rdData = {2'h0, pinPullupEnable};
      `SPC_ADDR_CHANGE: next_rdData = {2'h0, pinChangeEnable};
      `SPC_ADDR_ANALOG: next_rdData = {2'h0, pinAnalogSelect};
      `SPC_ADDR_INTCTL: next_rdData = {4'h0, changeInterruptEnable, 2'h0, changeInterruptFlag};
      `SPC_ADDR_OPTION: next_rdData = {globalPullupDisable, 7'h00};
      default: next_rdData = 8'h00;
    endcase
  end

  // read data one cycle later
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= regRead ? next_rdData : 8'h00;
    end
  end

  // configuration registers; soft reset restores defaults, power-on reset does not touch them
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      portDirection <= `SPC_DIR_RESET;
      pinPullupEnable <= `SPC_PULLUP_RESET;
      pinAnalogSelect <= `SPC_ANALOG_RESET;
      changeInterruptEnable <= 1'b0;
      globalPullupDisable <= 1'b1; // R08
    end else if (regWrite) begin
      if (hitReg(regAddr, `SPC_ADDR_DIR)) begin
        portDirection <= regWrData[5:0] | ~`SPC_DIR_MASK; // R20
      end
      if (hitReg(regAddr, `SPC_ADDR_PULLUP)) begin
        pinPullupEnable <= regWrData[5:0]; // R06
      end
      if (hitReg(regAddr, `SPC_ADDR_ANALOG)) begin
        pinAnalogSelect <= regWrData[5:0] & `SPC_ANALOG_MASK; // R17
      end
      if (hitReg(regAddr, `SPC_ADDR_INTCTL)) begin
        changeInterruptEnable <= regWrData[`SPC_INT_EN_BIT];
      end
      if (hitReg(regAddr, `SPC_ADDR_OPTION)) begin
        globalPullupDisable <= regWrData[`SPC_PU_DIS_BIT];
      end
    end
  end

  // change enables cleared by power-on only, so a soft reset keeps flagging a mismatch
  always_ff @(posedge clk_sys) begin
    if (porReset) begin
      pinChangeEnable <= `SPC_CHANGE_RESET; // R10 R15
    end else if (regWrite && hitReg(regAddr, `SPC_ADDR_CHANGE)) begin
      pinChangeEnable <= regWrData[5:0]; // R10
    end
  end

  // output latch is undefined at power-up; cleared here for determinism
  always_ff @(posedge clk_sys) begin
    if (porReset) begin
      outLatch <= 6'h00;
    end else if (regWrite && hitReg(regAddr, `SPC_ADDR_PORT)) begin
      outLatch <= next_outLatch; // R03
    end
  end

  // last-read latch only cleared by power-on reset
  always_ff @(posedge clk_sys) begin
    if (porReset) begin
      lastRead <= 6'h00;
    end else if (portAccess) begin
      lastRead <= digitalIn; // R15 R21
    end
  end

  // flag: set wins over clear, also in a port access cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      changeInterruptFlag <= 1'b0;
    end else if (anyMismatch) begin
      changeInterruptFlag <= 1'b1; // R14 R16
    end else if (regWrite && hitReg(regAddr, `SPC_ADDR_INTCTL)) begin
      changeInterruptFlag <= regWrData[`SPC_INT_FLAG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_dir_drive;
    @(posedge clk_sys) disable iff (reset) pinOe == ~portDirection;
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("drive enable wrong"); // R01

  property p_port_read;
    @(posedge clk_sys) disable iff (reset)
      (regRead && regAddr == `SPC_ADDR_PORT) |=> regRdData[5:0] == $past(pinIn & ~pinAnalogSelect);
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read not pin level"); // R02

  property p_rmw;
    @(posedge clk_sys) disable iff (reset || porReset)
      (regWrite && regAddr == `SPC_ADDR_PORT) |=> outLatch == $past(regWrData[5:0]);
  endproperty
  a_rmw: assert property (p_rmw) else $error("latch not written"); // R03

  property p_analog_zero;
    @(posedge clk_sys) disable iff (reset)
      (regRead && regAddr == `SPC_ADDR_PORT) |=> (regRdData[5:0] & $past(pinAnalogSelect)) == 6'h00;
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero"); // R05

  property p_pullup_out_off;
    @(posedge clk_sys) disable iff (reset)
      (pinOe & pinPullup) == 6'h00;
  endproperty
  a_pullup_out_off: assert property (p_pullup_out_off) else $error("pull-up on output pin"); // R07

  property p_global_off;
    @(posedge clk_sys) disable iff (reset)
      globalPullupDisable |-> (pinPullup & 6'h37) == 6'h00;
  endproperty
  a_global_off: assert property (p_global_off) else $error("pull-up while disabled"); // R08

  property p_master_clear_reset_pullup;
    @(posedge clk_sys) disable iff (reset) masterClearPinEnable |-> pinPullup[3];
  endproperty
  a_master_clear_reset_pullup: assert property (p_master_clear_reset_pullup) else $error("pin3 pull-up missing"); // R09

  property p_change_reset;
    @(posedge clk_sys) $fell(porReset) |-> pinChangeEnable == 6'h00;
  endproperty
  a_change_reset: assert property (p_change_reset) else $error("change enables not cleared"); // R10

  property p_irq_gate;
    @(posedge clk_sys) disable iff (reset) changeIrq |-> changeInterruptEnable && changeInterruptFlag;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable"); // R11

  property p_mismatch_sets;
    @(posedge clk_sys) disable iff (reset) anyMismatch |=> changeInterruptFlag;
  endproperty
  a_mismatch_sets: assert property (p_mismatch_sets) else $error("flag not set"); // R12 R14 R16

  property p_dir3;
    @(posedge clk_sys) disable iff (reset) portDirection[3] && !pinOe[3];
  endproperty
  a_dir3: assert property (p_dir3) else $error("pin3 not input"); // R20

  property p_reload;
    @(posedge clk_sys) disable iff (reset || porReset)
      portAccess |=> lastRead == $past(digitalIn);
  endproperty
  a_reload: assert property (p_reload) else $error("last-read not reloaded"); // R21

  // register writes land as written, masks applied
  property p_dir_write;
    @(posedge clk_sys) disable iff (reset)
      (regWrite && regAddr == `SPC_ADDR_DIR) |=> portDirection == ($past(regWrData[5:0]) | ~`SPC_DIR_MASK);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write wrong"); // R01

  property p_pullup_write;
    @(posedge clk_sys) disable iff (reset)
      (regWrite && regAddr == `SPC_ADDR_PULLUP) |=> pinPullupEnable == $past(regWrData[5:0]);
  endproperty
  a_pullup_write: assert property (p_pullup_write) else $error("pull-up enable write wrong"); // R06

  property p_change_write;
    @(posedge clk_sys) disable iff (reset || porReset)
      (regWrite && regAddr == `SPC_ADDR_CHANGE) |=> pinChangeEnable == $past(regWrData[5:0]);
  endproperty
  a_change_write: assert property (p_change_write) else $error("change enable write wrong"); // R10

  property p_analog_write;
    @(posedge clk_sys) disable iff (reset)
      (regWrite && regAddr == `SPC_ADDR_ANALOG) |=> pinAnalogSelect == ($past(regWrData[5:0]) & `SPC_ANALOG_MASK);
  endproperty
  a_analog_write: assert property (p_analog_write) else $error("analog select write wrong"); // R17

  property p_analog_unused;
    @(posedge clk_sys) disable iff (reset)
      (pinAnalogSelect & ~`SPC_ANALOG_MASK) == 6'h00;
  endproperty
  a_analog_unused: assert property (p_analog_unused) else $error("analog select on pin without it"); // R17

  // read port answers one cycle later and only then
  property p_dir_read;
    @(posedge clk_sys) disable iff (reset)
      (regRead && regAddr == `SPC_ADDR_DIR) |=> regRdData == {2'h0, $past(portDirection)};
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read wrong"); // R20

  property p_rd_idle;
    @(posedge clk_sys) disable iff (reset)
      !regRead |=> regRdData == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read"); // R02

  property p_rd_reserved;
    @(posedge clk_sys) disable iff (reset)
      (regRead && regAddr == `SPC_ADDR_PORT) |=> regRdData[7:6] == 2'h0;
  endproperty
  a_rd_reserved: assert property (p_rd_reserved) else $error("reserved port bits set"); // R02

  // output latch only moves on a port write, soft reset leaves it
  property p_latch_hold;
    @(posedge clk_sys) disable iff (porReset)
      !(regWrite && regAddr == `SPC_ADDR_PORT) |=> $stable(outLatch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved without write"); // R02

  property p_drive_value;
    @(posedge clk_sys) disable iff (reset)
      (pinOe & (pinOut ^ outLatch)) == 6'h00;
  endproperty
  a_drive_value: assert property (p_drive_value) else $error("driven pin not latch value"); // R01

  // pull-up gating
  property p_pullup_needs_enable;
    @(posedge clk_sys) disable iff (reset)
      (pinPullup & ~pinPullupEnable & `SPC_DIR_MASK) == 6'h00;
  endproperty
  a_pullup_needs_enable: assert property (p_pullup_needs_enable) else $error("pull-up without enable"); // R06

  property p_pullup_on;
    @(posedge clk_sys) disable iff (reset)
      !globalPullupDisable |-> (pinPullupEnable & portDirection & ~pinPullup) == 6'h00;
  endproperty
  a_pullup_on: assert property (p_pullup_on) else $error("enabled pull-up missing"); // R06 R08

  property p_pullup_analog_free;
    @(posedge clk_sys) disable iff (reset)
      ($changed(pinAnalogSelect) && $stable(pinPullupEnable) && $stable(portDirection) &&
        $stable(globalPullupDisable) && $stable(masterClearPinEnable)) |-> $stable(pinPullup);
  endproperty
  a_pullup_analog_free: assert property (p_pullup_analog_free) else $error("analog select moved pull-up"); // R19

  // change flag behaviour
  property p_flag_clear;
    @(posedge clk_sys) disable iff (reset)
      (regWrite && regAddr == `SPC_ADDR_INTCTL && !regWrData[`SPC_INT_FLAG_BIT] && !anyMismatch) |=> !changeInterruptFlag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // R14

  property p_flag_hold;
    @(posedge clk_sys) disable iff (reset)
      (changeInterruptFlag && !(regWrite && regAddr == `SPC_ADDR_INTCTL)) |=> changeInterruptFlag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped by itself"); // R14

  property p_flag_rise;
    @(posedge clk_sys) disable iff (reset)
      $rose(changeInterruptFlag) |->
        ($past(anyMismatch) || $past(regWrite && regAddr == `SPC_ADDR_INTCTL && regWrData[`SPC_INT_FLAG_BIT]));
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag set without cause"); // R12

  property p_wake_irq;
    @(posedge clk_sys) disable iff (reset)
      changeWake == changeIrq;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake differs from irq"); // R13

  property p_irq_when;
    @(posedge clk_sys) disable iff (reset)
      (changeInterruptFlag && changeInterruptEnable) |-> changeIrq;
  endproperty
  a_irq_when: assert property (p_irq_when) else $error("irq missing"); // R11

  // last-read latch and change enables survive soft reset
  property p_reload_write;
    @(posedge clk_sys) disable iff (reset || porReset)
      (regWrite && regAddr == `SPC_ADDR_PORT) |=> lastRead == $past(digitalIn);
  endproperty
  a_reload_write: assert property (p_reload_write) else $error("port write kept old last-read"); // R21

  property p_lastread_hold;
    @(posedge clk_sys) disable iff (porReset)
      !portAccess |=> $stable(lastRead);
  endproperty
  a_lastread_hold: assert property (p_lastread_hold) else $error("last-read moved"); // R15

  property p_change_hold;
    @(posedge clk_sys) disable iff (porReset)
      !(regWrite && regAddr == `SPC_ADDR_CHANGE) |=> $stable(pinChangeEnable);
  endproperty
  a_change_hold: assert property (p_change_hold) else $error("change enables moved"); // R15

  // values right after every soft reset release
  property p_dir_reset;
    @(posedge clk_sys)
      $fell(reset) |-> portDirection == `SPC_DIR_RESET;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not input after reset"); // R01

  property p_gdis_reset;
    @(posedge clk_sys)
      $fell(reset) |-> globalPullupDisable;
  endproperty
  a_gdis_reset: assert property (p_gdis_reset) else $error("pull-ups not disabled after reset"); // R08

  property p_analog_reset;
    @(posedge clk_sys)
      $fell(reset) |-> pinAnalogSelect == `SPC_ANALOG_RESET;
  endproperty
  a_analog_reset: assert property (p_analog_reset) else $error("analog select not reset"); // R17

  property p_irq_reset;
    @(posedge clk_sys)
      $fell(reset) |-> (!changeInterruptEnable && !changeIrq);
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("irq enabled after reset"); // R11
endmodule
`default_nettype wire

// ==== verilog/spc_defines.svh ====
// constants of the six pin change-detect port: offsets, fields, resets
// Operation
// R01: direction 1 input, 0 drives latch
// R02: data read gives pins, write hits latch
// R03: port write is read-modify-write
// R04: direction still drives analog pins
// R05: analog pin reads back zero
// R06: six per-pin pull-up enable bits
// R07: output pins lose pull-up
// R08: global disable gates all pull-ups; the pin3 master-clear pull-up is not gated by it
// R09: master-clear enable forces pin3 pull-up
// R10: six change enables, cleared at reset
// R11: change interrupt needs change enable bit
// R12: compare pins with last-read latch
// R13: change condition wakes device
// R14: persisting mismatch keeps setting flag
// R15: last-read latch survives soft resets
// R16: change during read still sets flag
// R17: analog select on pins 4,2,1,0
// R18: analog select leaves outputs alone
// R19: analog select leaves pull-ups alone
// R20: pin3 input only, direction reads 1
// R21: data access reloads last-read latch
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH
`define SPC_ADDR_PORT 3'h0
`define SPC_ADDR_DIR 3'h1
`define SPC_ADDR_PULLUP 3'h2
`define SPC_ADDR_CHANGE 3'h3
`define SPC_ADDR_ANALOG 3'h4
`define SPC_ADDR_INTCTL 3'h5
`define SPC_ADDR_OPTION 3'h6
`define SPC_PIN_MASK 6'h3f
`define SPC_DIR_MASK 6'h37
`define SPC_ANALOG_MASK 6'h17
`define SPC_DIR_RESET 6'h3f
`define SPC_PULLUP_RESET 6'h3f
`define SPC_CHANGE_RESET 6'h00
`define SPC_ANALOG_RESET 6'h17
`define SPC_INT_FLAG_BIT 0
`define SPC_INT_EN_BIT 3
`define SPC_PU_DIS_BIT 7
`define SPC_PIN3 3
`endif

// ==== verilog/spc_pkg.sv ====
// types of the six pin change-detect port
package spc_pkg;
  typedef logic [5:0] spc_pins_t;
  typedef logic [7:0] spc_byte_t;
  typedef logic [2:0] spc_addr_t;
endpackage

// ==== sim/spc_pin_board.sv ====
// board model: the six pins with outside drivers and a board pull-down
`timescale 1ns/100ps
`default_nettype none
module spc_pin_board (
  // port side
  input wire spc_pkg::spc_pins_t pinOut,
  input wire spc_pkg::spc_pins_t pinOe,
  input wire spc_pkg::spc_pins_t pinPullup,
  // outside drivers set by the bench
  input wire spc_pkg::spc_pins_t extDrive,
  input wire spc_pkg::spc_pins_t extLevel,
  // level seen at the pins
  output wire spc_pkg::spc_pins_t pinIn
);
  import spc_pkg::*;
  // port driver first, then outside driver; a released pin falls to the pull-up or the board pull-down
  assign pinIn = (pinOe & pinOut) | (~pinOe & extDrive & extLevel) | (~pinOe & ~extDrive & pinPullup);
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the six pin change-detect port
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"
module testbench;
  import spc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic porReset = 1'b1;
  logic masterClearPinEnable = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic changeIrq;
  logic changeWake;
  spc_addr_t regAddr = 3'h0;
  spc_byte_t regWrData = 8'h00;
  spc_byte_t regRdData;
  spc_byte_t rd;
  spc_pins_t pinIn, pinOut, pinOe, pinPullup;
  spc_pins_t extDrive = 6'h00;
  spc_pins_t extLevel = 6'h00;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  spc_port DUT (.clk_sys(clk_sys), .reset(reset), .porReset(porReset),
    .masterClearPinEnable(masterClearPinEnable), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pinPullup(pinPullup), .changeIrq(changeIrq), .changeWake(changeWake));
  spc_pin_board board (.pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPullup), .extDrive(extDrive),
    .extLevel(extLevel), .pinIn(pinIn));

  ////////////////////////////////////////////////////////////////
  // clock and hang guard, far above the roughly 70 cycles needed
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(string name, spc_byte_t exp, spc_byte_t got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // register port: one-cycle strobes, results looked at once the edge has landed
  task automatic wr(spc_addr_t a, spc_byte_t d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    #1;
  endtask

  task automatic rdchk(string n, spc_addr_t a, spc_byte_t e);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    chk(n, e, regRdData);
  endtask

  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_reset();
    rdchk("dir", `SPC_ADDR_DIR, 8'h3f);
    rdchk("pullen", `SPC_ADDR_PULLUP, 8'h3f);
    rdchk("chgen", `SPC_ADDR_CHANGE, 8'h00);
    rdchk("analog", `SPC_ADDR_ANALOG, 8'h17);
    rdchk("unmapped", 3'h7, 8'h00);
    chk("pullup master_clear_reset", 8'h08, {2'b00, pinPullup});
    chk("oe", 8'h00, {2'b00, pinOe});
    @(posedge clk_sys);
    masterClearPinEnable <= 1'b0;
    wr(`SPC_ADDR_DIR, 8'h00);
    rdchk("dir pin3", `SPC_ADDR_DIR, 8'h08);
    chk("pullup gdis", 8'h00, {2'b00, pinPullup});
  endtask

  task automatic test_drive();
    wr(`SPC_ADDR_OPTION, 8'h00);
    chk("oe", 8'h37, {2'b00, pinOe});
    chk("pullup out", 8'h08, {2'b00, pinPullup});
    wr(`SPC_ADDR_PORT, 8'h15);
    chk("latch", 8'h15, {2'b00, pinOut});
    rdchk("port analog", `SPC_ADDR_PORT, 8'h08);
    wr(`SPC_ADDR_ANALOG, 8'h00);
    rdchk("port digital", `SPC_ADDR_PORT, 8'h1d);
    wr(`SPC_ADDR_DIR, 8'h3f);
    wr(`SPC_ADDR_ANALOG, 8'h17);
    chk("pullup analog", 8'h3f, {2'b00, pinPullup});
    wr(`SPC_ADDR_ANALOG, 8'h00);
  endtask

  task automatic test_change();
    wr(`SPC_ADDR_CHANGE, 8'h08);
    wr(`SPC_ADDR_INTCTL, 8'h08);
    rdchk("port", `SPC_ADDR_PORT, 8'h3f);
    chk("irq idle", 8'h00, {7'h00, changeIrq});
    @(posedge clk_sys);
    extDrive <= 6'h08;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq", 8'h01, {7'h00, changeIrq});
    chk("wake", 8'h01, {7'h00, changeWake});
    rdchk("port low", `SPC_ADDR_PORT, 8'h37);
    wr(`SPC_ADDR_INTCTL, 8'h08);
    chk("irq cleared", 8'h00, {7'h00, changeIrq});
    // pin released in the same cycle as a port read
    @(posedge clk_sys);
    regAddr <= `SPC_ADDR_PORT;
    regRead <= 1'b1;
    extDrive <= 6'h00;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    chk("port race", 8'h3f, regRdData);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq read race", 8'h01, {7'h00, changeIrq});
    // pin3 low again: a lasting mismatch that only a port access clears
    @(posedge clk_sys);
    extDrive <= 6'h08;
    wr(`SPC_ADDR_INTCTL, 8'h00);
    chk("irq masked", 8'h00, {7'h00, changeIrq});
    wr(`SPC_ADDR_INTCTL, 8'h08);
    chk("irq persists", 8'h01, {7'h00, changeIrq});
    wr(`SPC_ADDR_PORT, 8'h00);
    wr(`SPC_ADDR_INTCTL, 8'h08);
    chk("irq after write", 8'h00, {7'h00, changeIrq});
  endtask

  task automatic test_soft_reset();
    @(posedge clk_sys);
    extLevel <= 6'h08;
    @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    rdchk("chgen kept", `SPC_ADDR_CHANGE, 8'h08);
    rdchk("flag again", `SPC_ADDR_INTCTL, 8'h01);
    chk("irq after reset", 8'h00, {7'h00, changeIrq});
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    porReset <= 1'b0;
    test_reset();
    test_drive();
    test_change();
    test_soft_reset();
    stop_test();
  end
endmodule
`default_nettype wire
